// [edr_phase_symbol_mapper.sv]
// Transmit symbol mapper: packet bits to FSK bits or differential phase steps
`default_nettype none
module edr_phase_symbol_mapper (
    input  wire logic               i_clk,
    input  wire logic               i_reset_n,
    input  wire logic               i_pkt_start,
    input  wire epm_pkg::epm_rate_t i_rate,
    input  wire logic               i_in_payload,
    input  wire logic               i_link_mgmt,
    input  wire logic               i_bit,
    input  wire logic               i_bit_valid,
    output logic                    o_bit_ready,
    output logic                    o_sym_valid,
    output logic                    o_is_psk,
    output logic                    o_fsk_bit,
    output logic              [2:0] o_phase_inc,
    output logic              [2:0] o_phase,
    output logic                    o_slot_start,
    output logic                    o_starved
);
    epm_tick_if tick ();

    epm_sym_timer u_timer (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .tick      (tick.timer)
    );

    assign tick.restart = i_pkt_start;

    epm_pkg::epm_rate_t eff_rate;
    logic [1:0] need;
    logic       psk_sel;
    logic       take;
    logic       fire;
    logic [2:0] map_inc;
    logic [2:0] map_bits;

    logic [2:0] col_r;
    logic [2:0] col_nxt;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic       ready_r;
    logic       ready_nxt;
    logic       sym_r;
    logic       sym_nxt;
    logic       psk_r;
    logic       psk_nxt;
    logic       fsk_r;
    logic       fsk_nxt;
    logic [2:0] inc_r;
    logic [2:0] inc_nxt;
    logic [2:0] phase_r;
    logic [2:0] phase_nxt;
    logic       slot_r;
    logic       slot_nxt;
    logic       starve_r;
    logic       starve_nxt;

    // Headers and link management frames never leave frequency-shift keying
    always_comb begin
        if (i_link_mgmt || !i_in_payload) begin
            eff_rate = epm_pkg::EPM_RATE_BASIC;
        end else begin
            eff_rate = i_rate;
        end
        case (eff_rate)
            epm_pkg::EPM_RATE_DQPSK: need = epm_pkg::BITS_DQPSK;
            epm_pkg::EPM_RATE_8DPSK: need = epm_pkg::BITS_8DPSK;
            default:                 need = epm_pkg::BITS_BASIC;
        endcase
        psk_sel  = (need != epm_pkg::BITS_BASIC);
        // Earliest bit of the group sits in the MSB
        map_bits = (need == epm_pkg::BITS_8DPSK) ? col_r : {1'b0, col_r[1:0]};
    end

    epm_phase_map u_map (
        .i_bits      (map_bits),
        .i_three_bit (need == epm_pkg::BITS_8DPSK),
        .o_inc       (map_inc)
    );

    always_comb begin
        take       = ready_r && i_bit_valid;
        fire       = tick.sym_tick && (cnt_r == need);
        col_nxt    = col_r;
        cnt_nxt    = fire ? 2'h0 : cnt_r;
        if (take) begin
            col_nxt = {col_r[1:0], i_bit};
            cnt_nxt = cnt_nxt + 2'h1;
        end
        sym_nxt    = fire;
        starve_nxt = tick.sym_tick && !fire;
        psk_nxt    = psk_r;
        fsk_nxt    = fsk_r;
        inc_nxt    = inc_r;
        phase_nxt  = phase_r;
        if (fire) begin
            psk_nxt = psk_sel;
            if (psk_sel) begin
                inc_nxt   = map_inc;
                phase_nxt = phase_r + map_inc;
            end else begin
                fsk_nxt   = col_r[0];
                inc_nxt   = 3'h0;
            end
        end
        // Differential chain restarts from a known reference each packet
        if (i_pkt_start) begin
            cnt_nxt   = 2'h0;
            phase_nxt = epm_pkg::PHASE_RESET;
        end
        ready_nxt  = (cnt_nxt < need);
        slot_nxt   = tick.slot_tick;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            col_r    <= 3'h0;
            cnt_r    <= 2'h0;
            ready_r  <= 1'b0;
            sym_r    <= 1'b0;
            psk_r    <= 1'b0;
            fsk_r    <= 1'b0;
            inc_r    <= 3'h0;
            phase_r  <= epm_pkg::PHASE_RESET;
            slot_r   <= 1'b0;
            starve_r <= 1'b0;
        end else begin
            col_r    <= col_nxt;
            cnt_r    <= cnt_nxt;
            ready_r  <= ready_nxt;
            sym_r    <= sym_nxt;
            psk_r    <= psk_nxt;
            fsk_r    <= fsk_nxt;
            inc_r    <= inc_nxt;
            phase_r  <= phase_nxt;
            slot_r   <= slot_nxt;
            starve_r <= starve_nxt;
        end
    end

    assign o_bit_ready  = ready_r;
    assign o_sym_valid  = sym_r;
    assign o_is_psk     = psk_r;
    assign o_fsk_bit    = fsk_r;
    assign o_phase_inc  = inc_r;
    assign o_phase      = phase_r;
    assign o_slot_start = slot_r;
    assign o_starved    = starve_r;

    // Checking helpers: cycles between symbol strobes
    logic [5:0] gap_r;
    logic       gap_seen_r;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            gap_r      <= 6'h0;
            gap_seen_r <= 1'b0;
        end else if (tick.sym_tick || i_pkt_start) begin
            gap_r      <= 6'h0;
            // A strobe in the restart cycle is followed by a stretched gap, so it does not count
            gap_seen_r <= tick.sym_tick && !i_pkt_start;
        end else begin
            gap_r      <= gap_r + 6'h1;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_psk_fire;
        fire && psk_sel && !i_pkt_start;
    endsequence

    gfsk_one_bit_a: assert property ((fire && !psk_sel) |-> ##1 (o_sym_valid && !o_is_psk && o_fsk_bit == $past(col_r[0])))
        else $error("basic symbol does not carry its one bit");
    sym_period_a: assert property ((tick.sym_tick && gap_seen_r && !$past(i_pkt_start)) |-> gap_r == 6'(epm_pkg::SYM_CYC - 1))
        else $error("symbol strobe spacing wrong");
    psk_bits_a: assert property (s_psk_fire |-> (cnt_r == 2'h2 || cnt_r == 2'h3) && cnt_r == need)
        else $error("phase symbol not two or three bits");
    mgmt_fsk_a: assert property ((fire && (i_link_mgmt || !i_in_payload)) |=> !o_is_psk)
        else $error("management or header symbol sent as phase symbol");
    dqpsk_map_a: assert property ((s_psk_fire and (need == 2'h2)) |=>
            o_phase_inc == {$past(col_r[1]), $past(col_r[1]) ^ $past(col_r[0]), 1'b1})
        else $error("two-bit increment wrong");
    dqpsk_step_a: assert property ((s_psk_fire and (need == 2'h2)) |=> o_phase_inc[0] && o_phase[0] != $past(phase_r[0]))
        else $error("two-bit step not 45 or 135 degrees");
    no_half_turn_a: assert property ((o_sym_valid && o_is_psk && $past(need) == 2'h2) |-> o_phase_inc != 3'h4)
        else $error("two-bit half turn step");
    diff_phase_a: assert property (s_psk_fire |=> o_phase == 3'($past(phase_r) + o_phase_inc))
        else $error("phase not previous plus increment");
    dpsk8_group_a: assert property ((fire && need == 2'h3) |=> o_is_psk && o_sym_valid [*1] ##1 !o_sym_valid)
        else $error("three-bit symbol not emitted as one symbol");
    dpsk8_map_a: assert property ((s_psk_fire and (need == 2'h3)) |=> o_phase_inc ==
            {$past(col_r[2]), $past(col_r[2] ^ col_r[1]), $past(col_r[2] ^ col_r[1] ^ col_r[0])})
        else $error("three-bit increment wrong");
    fsk_hold_a: assert property ((fire && !psk_sel && !i_pkt_start) |=> o_phase == $past(phase_r) && o_phase_inc == 3'h0)
        else $error("basic symbol moved the phase");
endmodule
`default_nettype wire

// [epm_bit_source.sv]
// Upstream packet bit source model feeding the symbol mapper
`default_nettype none
module epm_bit_source (
    input  wire logic i_clk,
    input  wire logic i_slow,
    input  wire logic i_ready,
    output logic      o_bit,
    output logic      o_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic q[$];
    logic last_r;

    initial begin
        o_bit = 1'b0;
        o_valid = 1'b0;
        last_r = 1'b0;
    end

    always @(posedge i_clk) begin
        if (o_valid && i_ready) begin
            last_r = q.pop_front();
        end
    end

    // Idle line shows the inverse of the last bit so a stale value is never read as fresh data
    always @(negedge i_clk) begin
        if (q.size() > 0 && (!i_slow || $urandom_range(3) == 0)) begin
            o_valid = 1'b1;
            o_bit = q[0];
        end else begin
            o_valid = 1'b0;
            o_bit = !last_r;
        end
    end
endmodule
`default_nettype wire

// [epm_phase_map.sv]
// Bit group to differential phase increment lookup
`default_nettype none
module epm_phase_map (
    input  wire logic [2:0] i_bits,
    input  wire logic       i_three_bit,
    output logic      [2:0] o_inc
);
    always_comb begin
        if (i_three_bit) begin
            o_inc = epm_pkg::DPSK8_INC[i_bits];
        end else begin
            // Only odd steps exist here, so no half turn can occur
            o_inc = epm_pkg::DQPSK_INC[i_bits[1:0]];
        end
    end
endmodule
`default_nettype wire

// [epm_pkg.sv]
// Shared constants and types for the transmit symbol mapper
`default_nettype none
package epm_pkg;
    localparam int unsigned CLK_HZ       = 50_000_000;
    localparam int unsigned SYMBOL_HZ    = 1_000_000;
    localparam int unsigned SLOT_HZ_X10  = 16_000;
    localparam int unsigned SYM_CYC      = CLK_HZ / SYMBOL_HZ;
    localparam int unsigned SLOT_SYMS    = (SYMBOL_HZ * 10) / SLOT_HZ_X10;
    localparam int unsigned SYM_CNT_W    = $clog2(SYM_CYC);
    localparam int unsigned SLOT_CNT_W   = $clog2(SLOT_SYMS);

    localparam logic [1:0] BITS_BASIC    = 2'h1;
    localparam logic [1:0] BITS_DQPSK    = 2'h2;
    localparam logic [1:0] BITS_8DPSK    = 2'h3;
    localparam logic [2:0] PHASE_RESET   = 3'h0;

    // Increments in pi/4 steps, indexed by the bit group, first bit as MSB
    localparam logic [2:0] DQPSK_INC [4] = '{3'h1, 3'h3, 3'h7, 3'h5};
    localparam logic [2:0] DPSK8_INC [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h7, 3'h6, 3'h4, 3'h5};

    typedef enum logic [1:0] {
        EPM_RATE_BASIC,
        EPM_RATE_DQPSK,
        EPM_RATE_8DPSK
    } epm_rate_t;
endpackage
`default_nettype wire

// [epm_sym_timer.sv]
// Divider producing the 1 MHz symbol enable and the slot enable
`default_nettype none
module epm_sym_timer (
    input  wire logic  i_clk,
    input  wire logic  i_reset_n,
    epm_tick_if.timer  tick
);
    logic [epm_pkg::SYM_CNT_W-1:0]  div_r;
    logic [epm_pkg::SYM_CNT_W-1:0]  div_nxt;
    logic [epm_pkg::SLOT_CNT_W-1:0] slot_r;
    logic [epm_pkg::SLOT_CNT_W-1:0] slot_nxt;
    logic                           sym_r;
    logic                           sym_nxt;
    logic                           slt_r;
    logic                           slt_nxt;

    assign tick.sym_tick  = sym_r;
    assign tick.slot_tick = slt_r;

    always_comb begin
        div_nxt  = div_r + 1'b1;
        slot_nxt = slot_r;
        sym_nxt  = 1'b0;
        slt_nxt  = 1'b0;
        if (div_r == epm_pkg::SYM_CNT_W'(epm_pkg::SYM_CYC - 1)) begin
            div_nxt = '0;
            sym_nxt = 1'b1;
            if (slot_r == epm_pkg::SLOT_CNT_W'(epm_pkg::SLOT_SYMS - 1)) begin
                slot_nxt = '0;
                slt_nxt  = 1'b1;
            end else begin
                slot_nxt = slot_r + 1'b1;
            end
        end
        // A new packet realigns the symbol grid to its first bit
        if (tick.restart) begin
            div_nxt  = '0;
            slot_nxt = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            div_r  <= '0;
            slot_r <= '0;
            sym_r  <= 1'b0;
            slt_r  <= 1'b0;
        end else begin
            div_r  <= div_nxt;
            slot_r <= slot_nxt;
            sym_r  <= sym_nxt;
            slt_r  <= slt_nxt;
        end
    end
endmodule
`default_nettype wire

// [epm_tick_if.sv]
// Symbol and slot timing strobes between the timer and the mapper
`default_nettype none
interface epm_tick_if;
    logic restart;
    logic sym_tick;
    logic slot_tick;
    modport timer (input restart, output sym_tick, output slot_tick);
    modport user  (output restart, input sym_tick, input slot_tick);
endinterface
`default_nettype wire

// [tb_edr_phase_symbol_mapper.sv]
// Self-checking bench for the transmit symbol mapper
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module tb_edr_phase_symbol_mapper;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic psk; logic dq; logic fsk; logic [2:0] inc; logic [2:0] ph;} epm_exp_t;
    logic clk = 1'b0, rst_n = 1'b0, pkt_start = 1'b0, in_payload = 1'b0, link_mgmt = 1'b0, slow = 1'b0;
    epm_pkg::epm_rate_t rate = epm_pkg::EPM_RATE_BASIC;
    logic       bit_in, bit_valid, bit_ready, sym_valid, is_psk, fsk_bit, slot_start, starved;
    logic [2:0] phase_inc, phase, prev_ph;
    epm_exp_t   expq[$];
    epm_exp_t   got_e;
    int         err_total, cmp_count, cyc, last_sym, last_slot, slot_n, starve_n;

    always #10 clk = ~clk;

    epm_bit_source u_src (.i_clk(clk), .i_slow(slow), .i_ready(bit_ready), .o_bit(bit_in), .o_valid(bit_valid));

    edr_phase_symbol_mapper u_dut (
        .i_clk(clk), .i_reset_n(rst_n), .i_pkt_start(pkt_start), .i_rate(rate), .i_in_payload(in_payload),
        .i_link_mgmt(link_mgmt), .i_bit(bit_in), .i_bit_valid(bit_valid), .o_bit_ready(bit_ready),
        .o_sym_valid(sym_valid), .o_is_psk(is_psk), .o_fsk_bit(fsk_bit), .o_phase_inc(phase_inc),
        .o_phase(phase), .o_slot_start(slot_start), .o_starved(starved));

    // Increment in pi/4 steps; both tables are gray orders
    function automatic logic [2:0] inc_of(input int n, input logic [2:0] g);
        if (n == 2) return {g[1], g[1] ^ g[0], 1'b1};
        if (n == 3) return {g[2], g[2] ^ g[1], ^g};
        return 3'h0;
    endfunction

    task automatic finish_test;
        if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic run_pkt(input epm_pkg::epm_rate_t r, input logic pay, input logic mgmt, input int nsym,
                           input logic slw);
        int n;
        logic [2:0] g, ph;
        n = (!pay || mgmt || r == epm_pkg::EPM_RATE_BASIC) ? 1 : (r == epm_pkg::EPM_RATE_DQPSK) ? 2 : 3;
        @(negedge clk);
        rate = r;
        in_payload = pay;
        link_mgmt = mgmt;
        slow = slw;
        pkt_start = 1'b1;
        @(negedge clk);
        pkt_start = 1'b0;
        ph = 3'h0;
        // Every code first, then random groups
        for (int k = 0; k < nsym; k++) begin
            g = (k < (1 << n)) ? 3'(k) : 3'($urandom);
            g = g & 3'((1 << n) - 1);
            ph = ph + inc_of(n, g);
            expq.push_back('{n > 1, n == 2, g[0], inc_of(n, g), ph});
            for (int b = n - 1; b >= 0; b--) u_src.q.push_back(g[b]);
        end
        for (int t = 0; t < 100 * nsym + 200 && expq.size() > 0; t++) @(negedge clk);
        `CHK(expq.size(), 0)
    endtask

    always @(posedge clk) begin
        cyc++;
        if (!rst_n || pkt_start) begin
            last_sym = -1;
            last_slot = -1;
            slot_n = 0;
            prev_ph = 3'h0;
        end else begin
            if (sym_valid || starved) begin
                if (last_sym >= 0) `CHK(cyc - last_sym, 50)
                last_sym = cyc;
            end
            if (starved) starve_n++;
            if (slot_start) begin
                if (last_slot >= 0) `CHK(cyc - last_slot, 31250)
                last_slot = cyc;
                slot_n++;
            end
            if (sym_valid) begin
                if (expq.size() == 0) `CHK(sym_valid, 1'b0)
                else begin
                    got_e = expq.pop_front();
                    `CHK(is_psk, got_e.psk)
                    if (!got_e.psk) `CHK(fsk_bit, got_e.fsk)
                    `CHK(phase_inc, got_e.inc)
                    `CHK(phase, got_e.ph)
                    `CHK(3'(phase - prev_ph), phase_inc)
                    if (got_e.dq) `CHK({phase_inc[0], phase_inc == 3'h4}, 2'h2)
                end
                prev_ph = phase;
            end
        end
    end

    initial begin
        void'($urandom(32'hca4db22b));
        repeat (12) @(negedge clk);
        `CHK({sym_valid, bit_ready, starved, phase}, 6'h00)
        rst_n = 1'b1;
        run_pkt(epm_pkg::EPM_RATE_BASIC, 1'b1, 1'b0, 20, 1'b0);
        run_pkt(epm_pkg::EPM_RATE_DQPSK, 1'b1, 1'b0, 40, 1'b0);
        run_pkt(epm_pkg::EPM_RATE_8DPSK, 1'b1, 1'b0, 40, 1'b1);
        run_pkt(epm_pkg::EPM_RATE_DQPSK, 1'b0, 1'b0, 12, 1'b0);
        run_pkt(epm_pkg::EPM_RATE_8DPSK, 1'b1, 1'b1, 12, 1'b1);
        // Idle run long enough to see two slot boundaries
        for (int t = 0; t < 70000 && slot_n < 2; t++) @(negedge clk);
        `CHK(slot_n, 2)
        `CHK(starve_n > 0, 1'b1)
        finish_test();
    end

    initial begin
        #(20 * 90000);
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
